//--- src/rgs_map.svh
`ifndef RGS_MAP_SVH
`define RGS_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RGS_OFS_FILTER 8'h00
`define RGS_OFS_GAIN1 8'h04
`define RGS_OFS_LOOP 8'h08
`define RGS_OFS_MANUAL 8'h0c
`define RGS_OFS_SQTIMER 8'h10
`define RGS_OFS_GSTATE 8'h14
`define RGS_OFS_RSSI 8'h18
`define RGS_OFS_CMD 8'h1c
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RGS_RST_FILTER 8'h00
`define RGS_RST_GAIN1 8'h06
`define RGS_RST_LOOP 8'h00
`define RGS_RST_MANUAL 8'h00
`define RGS_RST_SQTIMER 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RGS_LOOP_SQ_EN 0
`define RGS_LOOP_SQ_RATIO6 1
`define RGS_LOOP_AGC_EN 2
`define RGS_LOOP_AGC_FIRST8 3
`define RGS_LOOP_AGC_PRESET 4
`define RGS_LOOP_AGC_RATIO6 5
`define RGS_GAIN1_BOOST 3
`define RGS_CMD_RESET_GAIN 0
`define RGS_CMD_CLEAR_RSSI 1
// ----------------------------------------
// Step limits and timing
// ----------------------------------------
`define RGS_STEP_MAX 4'ha
`define RGS_WIN_MAX 4'h4
`define RGS_G1_MAX 3'h6
`define RGS_RSSI_MAX 4'hd
`define RGS_PULSES 4'h8
`define RGS_CLK_MHZ 50
`define RGS_SQ_DELAY_NS 18880
`define RGS_SQ_PERIOD_US 50
`endif

//--- src/rgs_pkg.sv
package rgs_pkg;
  typedef enum logic [2:0] {LP_1200K, LP_600K, LP_300K, LP_2M, LP_7M, LP_UNUSED} rgs_lp_e;
  typedef enum logic [1:0] {Z1_60K, Z1_40K, Z1_12K, Z1_HP600K} rgs_zero1_e;
  typedef enum logic [1:0] {Z3_400K, Z3_200K, Z3_80K, Z3_UNUSED} rgs_zero3_e;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_OBSERVE} rgs_sq_e;
  typedef struct packed {
    rgs_lp_e lowpassCorner;
    rgs_zero1_e firstZero;
    rgs_zero3_e thirdZero;
    logic [2:0] gain1Reduction;
    logic gain1Boost;
    logic [2:0] windowStep;
    logic [2:0] gain23Reduction;
    logic squelchRatio6;
    logic agcRatio6;
  } rgs_analog_s;
endpackage : rgs_pkg

//--- src/rgs_top.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "rgs_map.svh"
module rgs_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxRequest,
  input wire logic mrtRunning,
  input wire logic [7:0] mrtValue,
  input wire logic txEnd,
  input wire logic digMain,
  input wire logic digRatio6,
  input wire logic agcCmp,
  input wire logic subcarrierPulse,
  input wire logic [3:0] rssiAmLevel,
  input wire logic [3:0] rssiPmLevel,
  output logic rxOn,
  output rgs_pkg::rgs_analog_s analog
);
  localparam int SqDelayCyc = (`RGS_SQ_DELAY_NS * `RGS_CLK_MHZ + 999) / 1000;
  localparam int SqPeriodCyc = `RGS_SQ_PERIOD_US * `RGS_CLK_MHZ;
  localparam logic [11:0] SqDelayLast = 12'(SqDelayCyc - 1);
  localparam logic [11:0] SqPeriodLast = 12'(SqPeriodCyc - 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] filter_ff, nxt_filter;
  logic [7:0] gain1_ff, nxt_gain1;
  logic [7:0] loop_ff, nxt_loop;
  logic [7:0] manual_ff, nxt_manual;
  logic [7:0] sqTimer_ff, nxt_sqTimer;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [3:0] step_ff, nxt_step;
  logic [3:0] baseStep_ff, nxt_baseStep;
  logic [3:0] lastStep_ff, nxt_lastStep;
  logic [3:0] rssiAm_ff, nxt_rssiAm;
  logic [3:0] rssiPm_ff, nxt_rssiPm;
  logic rxOnD_ff, nxt_rxOnD;
  logic agcSrcD_ff, nxt_agcSrcD;
  logic sqSrcD_ff, nxt_sqSrcD;
  logic [3:0] pulseCnt_ff, nxt_pulseCnt;
  rgs_pkg::rgs_sq_e sqState_ff, nxt_sqState;
  logic [11:0] sqCnt_ff, nxt_sqCnt;
  logic [1:0] sqEdges_ff, nxt_sqEdges;
  rgs_pkg::rgs_analog_s analog_ff, nxt_analog;

  logic wrEn, rdEn, mapped, rxRise, rxFall, agcSrc, sqSrc;
  logic agcEdge, sqEdge, agcWindow, agcCut, sqCut, atMax, cmdResetGain, cmdClearRssi;
  logic [3:0] manualStep;

  // Mask timer blanks reception while no reply is expected
  assign rxOn = rxRequest & ~mrtRunning;
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign analog = analog_ff;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_filter = filter_ff;
    nxt_gain1 = gain1_ff;
    nxt_loop = loop_ff;
    nxt_manual = manual_ff;
    nxt_sqTimer = sqTimer_ff;
    nxt_prdata = prdata_ff;
    nxt_step = step_ff;
    nxt_baseStep = baseStep_ff;
    nxt_lastStep = lastStep_ff;
    nxt_rssiAm = rssiAm_ff;
    nxt_rssiPm = rssiPm_ff;
    nxt_pulseCnt = pulseCnt_ff;
    nxt_sqState = sqState_ff;
    nxt_sqCnt = sqCnt_ff;
    nxt_sqEdges = sqEdges_ff;
    nxt_rxOnD = rxOn;
    wrEn = psel & penable & pwrite;
    rdEn = psel & ~penable & ~pwrite;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= `RGS_OFS_CMD);
    pslverr = psel & penable & ~mapped;
    cmdResetGain = 1'b0;
    cmdClearRssi = 1'b0;
    // Bus writes
    if (wrEn && mapped) begin
      case (paddr)
        `RGS_OFS_FILTER: nxt_filter = pwdata[7:0];
        `RGS_OFS_GAIN1: nxt_gain1 = {4'h0, pwdata[3:0]};
        `RGS_OFS_LOOP: nxt_loop = {2'h0, pwdata[5:0]};
        `RGS_OFS_MANUAL: nxt_manual = {4'h0, pwdata[3:0]};
        `RGS_OFS_SQTIMER: nxt_sqTimer = pwdata[7:0];
        `RGS_OFS_CMD: begin
          cmdResetGain = pwdata[`RGS_CMD_RESET_GAIN];
          cmdClearRssi = pwdata[`RGS_CMD_CLEAR_RSSI];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in setup so the access phase needs no wait
    if (rdEn) begin
      case (paddr)
        `RGS_OFS_FILTER: nxt_prdata = {24'h0, filter_ff};
        `RGS_OFS_GAIN1: nxt_prdata = {24'h0, gain1_ff};
        `RGS_OFS_LOOP: nxt_prdata = {24'h0, loop_ff};
        `RGS_OFS_MANUAL: nxt_prdata = {24'h0, manual_ff};
        `RGS_OFS_SQTIMER: nxt_prdata = {24'h0, sqTimer_ff};
        `RGS_OFS_GSTATE: nxt_prdata = {24'h0, step_ff, lastStep_ff};
        `RGS_OFS_RSSI: nxt_prdata = {24'h0, rssiPm_ff, rssiAm_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    // Manual values beyond the top step clamp to it
    manualStep = (manual_ff[3:0] > `RGS_STEP_MAX) ? `RGS_STEP_MAX : manual_ff[3:0];
    rxRise = rxOn & ~rxOnD_ff;
    rxFall = ~rxOn & rxOnD_ff;
    // Comparator output doubles as the ratio 3/6 selected comparator
    agcSrc = agcCmp;
    sqSrc = loop_ff[`RGS_LOOP_SQ_RATIO6] ? digRatio6 : digMain;
    nxt_agcSrcD = agcSrc;
    nxt_sqSrcD = sqSrc;
    agcEdge = agcSrc ^ agcSrcD_ff;
    sqEdge = sqSrc ^ sqSrcD_ff;
    atMax = (step_ff >= `RGS_STEP_MAX);
    // ----------------------------------------
    // Automatic gain control
    // ----------------------------------------
    if (rxRise) begin
      nxt_pulseCnt = 4'h0;
    end else if (rxOn && subcarrierPulse && pulseCnt_ff < `RGS_PULSES) begin
      nxt_pulseCnt = pulseCnt_ff + 4'h1;
    end
    agcWindow = ~loop_ff[`RGS_LOOP_AGC_FIRST8] | (pulseCnt_ff < `RGS_PULSES);
    agcCut = loop_ff[`RGS_LOOP_AGC_EN] & rxOn & rxOnD_ff & agcWindow & agcEdge & ~atMax;
    // ----------------------------------------
    // Squelch
    // ----------------------------------------
    sqCut = 1'b0;
    case (sqState_ff)
      rgs_pkg::SQ_IDLE: begin
        if (txEnd && loop_ff[`RGS_LOOP_SQ_EN]) begin
          nxt_sqState = rgs_pkg::SQ_WAIT;
          nxt_sqCnt = 12'h0;
        end
      end
      rgs_pkg::SQ_WAIT: begin
        if (sqCnt_ff == SqDelayLast) begin
          nxt_sqState = rgs_pkg::SQ_OBSERVE;
          nxt_sqCnt = 12'h0;
          nxt_sqEdges = 2'h0;
        end else begin
          nxt_sqCnt = sqCnt_ff + 12'h1;
        end
      end
      rgs_pkg::SQ_OBSERVE: begin
        if (sqEdge && sqEdges_ff != 2'h3) begin
          nxt_sqEdges = sqEdges_ff + 2'h1;
        end
        if (sqCnt_ff == SqPeriodLast) begin
          nxt_sqCnt = 12'h0;
          nxt_sqEdges = 2'h0;
          if (sqEdges_ff == 2'h3 && !atMax) begin
            sqCut = 1'b1;
          end else begin
            nxt_sqState = rgs_pkg::SQ_IDLE;
          end
        end else begin
          nxt_sqCnt = sqCnt_ff + 12'h1;
        end
      end
      default: nxt_sqState = rgs_pkg::SQ_IDLE;
    endcase
    // Squelch ends once the mask timer reaches its programmed value
    if (sqState_ff != rgs_pkg::SQ_IDLE && (mrtValue >= sqTimer_ff || !loop_ff[`RGS_LOOP_SQ_EN])) begin
      nxt_sqState = rgs_pkg::SQ_IDLE;
    end
    // ----------------------------------------
    // Shared reduction step
    // ----------------------------------------
    if (rxFall) begin
      nxt_lastStep = step_ff;
    end
    if (cmdResetGain) begin
      nxt_step = manualStep;
      nxt_baseStep = manualStep;
      nxt_sqState = rgs_pkg::SQ_IDLE;
    end else if (rxFall) begin
      nxt_step = baseStep_ff;
    end else if (rxRise) begin
      nxt_baseStep = step_ff;
      if (loop_ff[`RGS_LOOP_AGC_EN]) begin
        nxt_step = loop_ff[`RGS_LOOP_AGC_PRESET] ? `RGS_WIN_MAX : 4'h0;
      end
    end else if (agcCut || sqCut) begin
      nxt_step = step_ff + 4'h1;
      if (sqCut && !rxOn) begin
        nxt_baseStep = step_ff + 4'h1;
      end
    end
    // ----------------------------------------
    // Signal strength peak hold
    // ----------------------------------------
    if (cmdClearRssi || rxRise || agcCut) begin
      nxt_rssiAm = 4'h0;
      nxt_rssiPm = 4'h0;
    end else if (rxOn) begin
      if (rssiAmLevel > rssiAm_ff) begin
        nxt_rssiAm = (rssiAmLevel > `RGS_RSSI_MAX) ? `RGS_RSSI_MAX : rssiAmLevel;
      end
      if (rssiPmLevel > rssiPm_ff) begin
        nxt_rssiPm = (rssiPmLevel > `RGS_RSSI_MAX) ? `RGS_RSSI_MAX : rssiPmLevel;
      end
    end
    // ----------------------------------------
    // Analog settings decode
    // ----------------------------------------
    case (filter_ff[5:3])
      3'h0: nxt_analog.lowpassCorner = rgs_pkg::LP_1200K;
      3'h1: nxt_analog.lowpassCorner = rgs_pkg::LP_600K;
      3'h2: nxt_analog.lowpassCorner = rgs_pkg::LP_300K;
      3'h4: nxt_analog.lowpassCorner = rgs_pkg::LP_2M;
      3'h6: nxt_analog.lowpassCorner = rgs_pkg::LP_7M;
      default: nxt_analog.lowpassCorner = rgs_pkg::LP_UNUSED;
    endcase
    // Zero bits share bit 3 with the low-pass code by design of the map
    if (filter_ff[3]) begin
      nxt_analog.firstZero = rgs_pkg::Z1_HP600K;
    end else if (filter_ff[0]) begin
      nxt_analog.firstZero = rgs_pkg::Z1_12K;
    end else if (filter_ff[1]) begin
      nxt_analog.firstZero = rgs_pkg::Z1_40K;
    end else begin
      nxt_analog.firstZero = rgs_pkg::Z1_60K;
    end
    case (filter_ff[3:0])
      4'h0, 4'h8: nxt_analog.thirdZero = rgs_pkg::Z3_400K;
      4'h4, 4'h1, 4'h5, 4'hc: nxt_analog.thirdZero = rgs_pkg::Z3_200K;
      4'h2, 4'h3: nxt_analog.thirdZero = rgs_pkg::Z3_80K;
      default: nxt_analog.thirdZero = rgs_pkg::Z3_UNUSED;
    endcase
    nxt_analog.gain1Reduction = (gain1_ff[2:0] > `RGS_G1_MAX) ? `RGS_G1_MAX : gain1_ff[2:0];
    nxt_analog.gain1Boost = gain1_ff[`RGS_GAIN1_BOOST];
    nxt_analog.windowStep = (step_ff > `RGS_WIN_MAX) ? 3'h4 : step_ff[2:0];
    nxt_analog.gain23Reduction = (step_ff > `RGS_WIN_MAX) ? 3'(step_ff - `RGS_WIN_MAX) : 3'h0;
    nxt_analog.squelchRatio6 = loop_ff[`RGS_LOOP_SQ_RATIO6];
    nxt_analog.agcRatio6 = loop_ff[`RGS_LOOP_AGC_RATIO6];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filter_ff <= `RGS_RST_FILTER;
      gain1_ff <= `RGS_RST_GAIN1;
      loop_ff <= `RGS_RST_LOOP;
      manual_ff <= `RGS_RST_MANUAL;
      sqTimer_ff <= `RGS_RST_SQTIMER;
      prdata_ff <= 32'h0;
      step_ff <= 4'h0;
      baseStep_ff <= 4'h0;
      lastStep_ff <= 4'h0;
      rssiAm_ff <= 4'h0;
      rssiPm_ff <= 4'h0;
      rxOnD_ff <= 1'b0;
      agcSrcD_ff <= 1'b0;
      sqSrcD_ff <= 1'b0;
      pulseCnt_ff <= 4'h0;
      sqState_ff <= rgs_pkg::SQ_IDLE;
      sqCnt_ff <= 12'h0;
      sqEdges_ff <= 2'h0;
      analog_ff <= '0;
    end else begin
      filter_ff <= nxt_filter;
      gain1_ff <= nxt_gain1;
      loop_ff <= nxt_loop;
      manual_ff <= nxt_manual;
      sqTimer_ff <= nxt_sqTimer;
      prdata_ff <= nxt_prdata;
      step_ff <= nxt_step;
      baseStep_ff <= nxt_baseStep;
      lastStep_ff <= nxt_lastStep;
      rssiAm_ff <= nxt_rssiAm;
      rssiPm_ff <= nxt_rssiPm;
      rxOnD_ff <= nxt_rxOnD;
      agcSrcD_ff <= nxt_agcSrcD;
      sqSrcD_ff <= nxt_sqSrcD;
      pulseCnt_ff <= nxt_pulseCnt;
      sqState_ff <= nxt_sqState;
      sqCnt_ff <= nxt_sqCnt;
      sqEdges_ff <= nxt_sqEdges;
      analog_ff <= nxt_analog;
    end
  end
endmodule : rgs_top

//--- sim/rgs_analog_model.sv
// ----
// Receive front-end stand-in
// ----
module rgs_analog_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic carrier,
  input wire logic noise,
  input wire logic noise6,
  input wire logic agcKick,
  output logic digMain,
  output logic digRatio6,
  output logic agcCmp,
  output logic subcarrierPulse,
  output logic [3:0] rssiAmLevel,
  output logic [3:0] rssiPmLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // Each noise source reaches one comparator only, so a wrong ratio pick shows up
  assign subcarrierPulse = carrier && cnt == 4'h0;
  // Without carrier the levels churn, so a frozen result cannot pass by luck
  assign rssiAmLevel = carrier ? 4'hf : cnt;
  assign rssiPmLevel = carrier ? 4'h9 : ~cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      digMain <= 1'b0;
      digRatio6 <= 1'b0;
      agcCmp <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      digMain <= digMain ^ (noise && cnt == 4'h0);
      digRatio6 <= digRatio6 ^ (noise6 && cnt == 4'h8);
      agcCmp <= agcCmp ^ agcKick;
    end
  end
endmodule : rgs_analog_model

//--- sim/rgs_top_sva.sv
`include "rgs_map.svh"
module rgs_top_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic rxRequest,
  input wire logic mrtRunning,
  input wire logic rxOn,
  input wire rgs_pkg::rgs_analog_s analog
);
  logic wrAcc;
  logic filtWr;
  logic [3:0] manual_ff;
  logic [3:0] nxt_manual;
  logic [3:0] stepSum;
  assign wrAcc = psel && penable && pwrite;
  assign filtWr = wrAcc && paddr == `RGS_OFS_FILTER;
  assign stepSum = {1'b0, analog.windowStep} + {1'b0, analog.gain23Reduction};
  // Shadow of the manual step, clamped on write as the design clamps it on use
  always_comb begin
    nxt_manual = manual_ff;
    if (wrAcc && paddr == `RGS_OFS_MANUAL) begin
      nxt_manual = (pwdata[3:0] > `RGS_STEP_MAX) ? `RGS_STEP_MAX : pwdata[3:0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      manual_ff <= 4'h0;
    end else begin
      manual_ff <= nxt_manual;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_wrAt(logic [7:0] ofs);
    wrAcc && paddr == ofs;
  endsequence
  sequence s_cmdReset;
    s_wrAt(`RGS_OFS_CMD) ##0 pwdata[`RGS_CMD_RESET_GAIN];
  endsequence
  a_rxon_mask: assert property (rxOn == (rxRequest && !mrtRunning))
    else $error("receive-active mismatch");
  a_step_order: assert property (analog.gain23Reduction != 3'h0 |-> analog.windowStep == `RGS_WIN_MAX)
    else $error("gain cut before window full");
  a_stage_range: assert property (analog.windowStep <= `RGS_WIN_MAX && analog.gain23Reduction <= 3'h6)
    else $error("stage setting out of range");
  a_lowpass_dec: assert property (filtWr && pwdata[5:3] == 3'h6 |-> ##2 analog.lowpassCorner == rgs_pkg::LP_7M)
    else $error("low-pass decode wrong");
  a_lowpass_hold: assert property ($changed(analog.lowpassCorner) |-> $past(filtWr, 2))
    else $error("low-pass changed without write");
  a_zero_dec: assert property (filtWr && pwdata[3:0] == 4'h2 |-> ##2
    analog.firstZero == rgs_pkg::Z1_40K && analog.thirdZero == rgs_pkg::Z3_80K) else $error("zero decode wrong");
  a_gain1_dec: assert property (s_wrAt(`RGS_OFS_GAIN1) ##0 pwdata[2:0] <= 3'h6 |-> ##2
    analog.gain1Reduction == $past(pwdata[2:0], 2) && analog.gain1Boost == $past(pwdata[3], 2))
    else $error("first-stage gain wrong");
  a_ratio_dec: assert property (s_wrAt(`RGS_OFS_LOOP) |-> ##2
    analog.squelchRatio6 == $past(pwdata[1], 2) && analog.agcRatio6 == $past(pwdata[5], 2))
    else $error("ratio select wrong");
  a_gain_reset: assert property (s_cmdReset |-> ##2 stepSum == $past(manual_ff, 2))
    else $error("gain reset did not load manual step");
  a_rssi_clip: assert property (psel && !penable && !pwrite && paddr == `RGS_OFS_RSSI |=>
    prdata[3:0] <= `RGS_RSSI_MAX && prdata[7:4] <= `RGS_RSSI_MAX) else $error("strength above maximum");
endmodule : rgs_top_sva
bind rgs_top rgs_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rxRequest(rxRequest), .mrtRunning(mrtRunning), .rxOn(rxOn),
  .analog(analog));

//--- sim/testbench.sv
`include "rgs_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic rxRequest, mrtRunning, txEnd, digMain, digRatio6, agcCmp, scPulse, rxOn, noise, noise6, agcKick;
  logic [7:0] paddr, mrtValue;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] rssiAm, rssiPm;
  rgs_pkg::rgs_analog_s analog;
  int err_total, check_count;
  logic [7:0] rAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
  logic [31:0] rExp [8] = '{32'h00, 32'h06, 32'h00, 32'h00, 32'h00, 32'h00, 32'h00, 32'h00};
  logic [31:0] lpCode [5] = '{32'h00, 32'h08, 32'h10, 32'h20, 32'h30};
  rgs_pkg::rgs_lp_e lpExp [5] = '{rgs_pkg::LP_1200K, rgs_pkg::LP_600K, rgs_pkg::LP_300K, rgs_pkg::LP_2M, rgs_pkg::LP_7M};
  logic [31:0] zCode [4] = '{32'h0, 32'h2, 32'h1, 32'h8};
  logic [3:0] zExp [4] = '{4'h0, 4'h6, 4'h9, 4'hc};
  logic [31:0] sqCfg [3] = '{32'h01, 32'h03, 32'h03};
  logic [31:0] sqExp [3] = '{32'h1a, 32'h0a, 32'h1a};
  logic [1:0] sqNoise [3] = '{2'b01, 2'b01, 2'b10};
  rgs_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxRequest(rxRequest),
    .mrtRunning(mrtRunning), .mrtValue(mrtValue), .txEnd(txEnd), .digMain(digMain), .digRatio6(digRatio6),
    .agcCmp(agcCmp), .subcarrierPulse(scPulse), .rssiAmLevel(rssiAm), .rssiPmLevel(rssiPm), .rxOn(rxOn),
    .analog(analog));
  rgs_analog_model model (.clk_sys(clk_sys), .rst_n(rst_n), .carrier(rxRequest), .noise(noise), .noise6(noise6),
    .agcKick(agcKick),
    .digMain(digMain), .digRatio6(digRatio6), .agcCmp(agcCmp), .subcarrierPulse(scPulse), .rssiAmLevel(rssiAm),
    .rssiPmLevel(rssiPm));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  // Each pulse flips the comparator once; gaps keep toggles apart
  task automatic kick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      agcKick <= 1'b1;
      @(posedge clk_sys);
      agcKick <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : kick
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // ----
  // Watchdog: the run needs about 20000 cycles
  // ----
  initial begin
    #(20 * 40000);
    err_total++;
    stop_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, rxRequest, mrtRunning, txEnd, noise, noise6, agcKick} = '0;
    {paddr, pwdata, mrtValue} = '0;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(1);
    chk(analog.gain1Reduction, `RGS_G1_MAX);
    wr(`RGS_OFS_GSTATE, 32'hff);
    foreach (rAddr[i]) begin
      rd(rAddr[i], rExp[i]);
      chk(err, i == 7);
    end
    foreach (lpCode[i]) begin
      wr(`RGS_OFS_FILTER, lpCode[i]);
      settle(2);
      chk(analog.lowpassCorner, lpExp[i]);
    end
    foreach (zCode[i]) begin
      wr(`RGS_OFS_FILTER, zCode[i]);
      settle(2);
      chk({analog.firstZero, analog.thirdZero}, zExp[i]);
    end
    wr(`RGS_OFS_GAIN1, 32'h0b);
    settle(2);
    chk({analog.gain1Boost, analog.gain1Reduction}, 4'hb);
    wr(`RGS_OFS_LOOP, 32'h22);
    settle(2);
    chk({analog.agcRatio6, analog.squelchRatio6}, 2'b11);
    wr(`RGS_OFS_MANUAL, 32'h7);
    wr(`RGS_OFS_CMD, 32'h1);
    settle(2);
    chk({analog.windowStep, analog.gain23Reduction}, 6'h23);
    rd(`RGS_OFS_GSTATE, 32'h70);
    wr(`RGS_OFS_MANUAL, 32'h0);
    wr(`RGS_OFS_CMD, 32'h1);
    wr(`RGS_OFS_LOOP, 32'h14);
    @(posedge clk_sys);
    rxRequest <= 1'b1;
    settle(3);
    chk(rxOn, 1'b1);
    rd(`RGS_OFS_GSTATE, 32'h40);
    kick(3);
    rd(`RGS_OFS_GSTATE, 32'h70);
    kick(5);
    rd(`RGS_OFS_GSTATE, 32'ha0);
    rd(`RGS_OFS_RSSI, 32'h9d);
    @(posedge clk_sys);
    rxRequest <= 1'b0;
    settle(3);
    rd(`RGS_OFS_GSTATE, 32'h0a);
    rd(`RGS_OFS_RSSI, 32'h9d);
    wr(`RGS_OFS_CMD, 32'h2);
    rd(`RGS_OFS_RSSI, 32'h0);
    wr(`RGS_OFS_SQTIMER, 32'hff);
    // Receiver is requested but masked, so squelch runs while receive-active stays low
    foreach (sqCfg[i]) begin
      wr(`RGS_OFS_CMD, 32'h1);
      wr(`RGS_OFS_LOOP, sqCfg[i]);
      @(posedge clk_sys);
      {rxRequest, mrtRunning, txEnd} <= 3'b111;
      {noise6, noise} <= sqNoise[i];
      mrtValue <= 8'h00;
      @(posedge clk_sys);
      txEnd <= 1'b0;
      settle(900);
      chk(rxOn, 1'b0);
      rd(`RGS_OFS_GSTATE, 32'h0a);
      settle(2600);
      rd(`RGS_OFS_GSTATE, sqExp[i]);
      @(posedge clk_sys);
      mrtValue <= 8'hff;
      settle(2600);
      rd(`RGS_OFS_GSTATE, sqExp[i]);
    end
    // First-eight-pulse mode with the reset start, from a nonzero manual step
    wr(`RGS_OFS_MANUAL, 32'h2);
    wr(`RGS_OFS_CMD, 32'h1);
    wr(`RGS_OFS_LOOP, 32'h0c);
    @(posedge clk_sys);
    mrtRunning <= 1'b0;
    settle(3);
    chk(rxOn, 1'b1);
    rd(`RGS_OFS_GSTATE, 32'h0a);
    kick(1);
    rd(`RGS_OFS_GSTATE, 32'h1a);
    settle(200);
    kick(2);
    rd(`RGS_OFS_GSTATE, 32'h1a);
    @(posedge clk_sys);
    mrtRunning <= 1'b1;
    settle(3);
    chk(rxOn, 1'b0);
    rd(`RGS_OFS_GSTATE, 32'h21);
    stop_test();
  end
endmodule : testbench
